// ---- common/dtcd_pkg.sv ----
// Purpose: constants for the dual timer with carrier demodulation
// Assumes: APB register bus, 8-bit registers at word-aligned addresses
// Notes: byte address of a register is four times its index
package dtcd_pkg;

    // ------------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------------
    localparam logic [3:0] IDX_BYTE_TIMER_CONTROL = 4'h0;
    localparam logic [3:0] IDX_TIMER_COMMON_CONTROL = 4'h1;
    localparam logic [3:0] IDX_WORD_TIMER_CONTROL = 4'h2;
    localparam logic [3:0] IDX_TIMER_ENABLE_LOCKSTEP = 4'h3;
    localparam logic [3:0] IDX_BYTE_RELOAD_LOW = 4'h4;
    localparam logic [3:0] IDX_BYTE_RELOAD_HIGH = 4'h5;
    localparam logic [3:0] IDX_WORD_RELOAD_LOW = 4'h6;
    localparam logic [3:0] IDX_WORD_RELOAD_HIGH = 4'h7;
    localparam logic [3:0] IDX_WORD_CAPTURE_LOW = 4'h8;
    localparam logic [3:0] IDX_WORD_CAPTURE_HIGH = 4'h9;
    localparam logic [3:0] IDX_BYTE_CAPTURE_LOW = 4'hA;
    localparam logic [3:0] IDX_BYTE_CAPTURE_HIGH = 4'hB;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    // common control
    localparam int CC_MODE = 7;
    localparam int CC_SELECT = 6;
    localparam int CC_LOGIC_HI = 5;
    localparam int CC_LOGIC_LO = 4;
    localparam int CC_PP_HI = 3;
    localparam int CC_PP_LO = 2;
    localparam int CC_BYTE_INIT = 1;
    localparam int CC_WORD_INIT = 0;
    // byte and word timer control
    localparam int TC_ENABLE = 7;
    localparam int TC_SINGLE = 6;
    localparam int WC_TIMEOUT = 5;
    localparam int BC_CLK_HI = 5;
    localparam int BC_CLK_LO = 4;
    localparam int WC_CLK_HI = 4;
    localparam int WC_CLK_LO = 3;
    localparam int BC_CAP_IE = 3;
    localparam int WC_CAP_IE = 2;
    localparam int TC_CNT_IE = 1;
    localparam int TC_PIN_SEL = 0;
    // enable/lockstep
    localparam int EL_WORD_EN = 7;
    localparam int EL_BYTE_EN = 6;
    localparam int EL_SYNC = 5;

    // ------------------------------------------------------------------
    // encodings and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] LOGIC_AND = 2'h0;
    localparam logic [1:0] LOGIC_OR = 2'h1;
    localparam logic [1:0] LOGIC_NOR = 2'h2;
    localparam logic [1:0] LOGIC_NAND = 2'h3;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [2:0] DIV_RESET = 3'h0;

endpackage : dtcd_pkg

// ---- verilog/dtcd_timer.sv ----
// Purpose: byte and word down-counters for carrier transmit and demodulation
// Assumes: APB slave, zero wait states, pins synchronous to mclk
// Notes: interrupt requests leave as one-cycle pulses, no status register
//
// What this block does
// (RULE_01) common control bit 7: 0 transmit, 1 demodulation; transmit after reset
// (RULE_02) bit 6 picks combined pin source in transmit, edge input in demod
// (RULE_03) transmit logic field combines timer outputs: AND, OR, NOR, NAND
// (RULE_04) demod logic field picks falling, rising or both edges
// (RULE_05) byte capture on an edge requests interrupt when capture enable set
// (RULE_06) byte terminal count requests interrupt when timeout enable set
// (RULE_07) byte pin select chooses port value or byte timer level
// (RULE_08) edge bit 0: word timer captures and reloads on every edge
// (RULE_09) edge bit 1: word timer captures and reloads on first edge only
// (RULE_10) first-edge mode: byte timeout makes word capture without reload
// (RULE_11) writing edge bit 0 then 1 rearms first-edge capture
// (RULE_12) word timer wraps to FFFF at zero in demod (reloads in transmit), sets timeout, may interrupt
// (RULE_13) word timeout status stays set until software writes 1
// (RULE_14) word capture requests interrupt when capture enable set
// (RULE_15) word timeout requests interrupt when timeout enable set
// (RULE_16) word pin select chooses port value or word timer level
// (RULE_17) lockstep reg: bits 7,6 run state and start/stop; bit 5 sync
// (RULE_18) software uses ping-pong only in transmit with single-pass timers
// (RULE_19) ping-pong byte timer starts at initial level, hands over at end
// (RULE_20) ping-pong word timer starts at initial level, hands back at end
// (RULE_21) writing 00 to ping-pong field ends alternation
// (RULE_22) software stops timers and clears flags before ping-pong
// (RULE_23) timers decrement per prescaled tick, terminal count at zero
// (RULE_24) clock select fields divide the system clock for each timer
`timescale 1ns/100ps
module dtcd_timer
    import dtcd_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic demodInputA,
    input wire logic demodInputB,
    input wire logic portOutByte,
    input wire logic portOutWord,
    input wire logic portOutCombined,
    output logic byteTimerOutPin,
    output logic wordTimerOutPin,
    output logic combinedOutPin,
    output logic byteIrq,
    output logic wordIrq
);

    // ------------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------------
    logic [7:0] byteCtl, wordCtl, commonCtl;
    logic syncEn;
    logic [7:0] byteReloadLow, byteReloadHigh, wordReloadLow, wordReloadHigh;
    logic [7:0] wordCaptureLow, wordCaptureHigh;
    logic [7:0] byteCaptureLow, byteCaptureHigh;
    logic byteRun, wordRun, next_byteRun, next_wordRun;
    logic [7:0] byteCount;
    logic [15:0] wordCount;
    logic byteLevel, wordLevel, wordTimeout, firstDone, prevIn;
    logic [2:0] divCnt;
    logic [7:0] rd8;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic [3:0] idx;
    logic addrOk, wr, byteStart, wordStart;
    assign idx = paddr[5:2];
    assign addrOk = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0)
                    && (idx <= IDX_BYTE_CAPTURE_HIGH);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addrOk;
    assign wr = psel && penable && pwrite && addrOk;

    function automatic logic wrAt(input logic [3:0] i);
        wrAt = wr && (idx == i);
    endfunction : wrAt

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    logic demod, ppOn, wSingle, bSingle;
    logic [1:0] logicSel;
    assign demod = commonCtl[CC_MODE]; // [RULE_01]
    assign logicSel = commonCtl[CC_LOGIC_HI:CC_LOGIC_LO];
    // alternation lives only while the field is nonzero in transmit
    assign ppOn = !demod && (commonCtl[CC_PP_HI:CC_PP_LO] != 2'h0); // [RULE_21]
    assign wSingle = wordCtl[TC_SINGLE];
    assign bSingle = byteCtl[TC_SINGLE];

    // ------------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------------
    logic byteTick, wordTick;

    function automatic logic tickOf(input logic [1:0] s, input logic [2:0] d);
        case (s)
            2'h0: tickOf = 1'b1;
            2'h1: tickOf = d[0];
            2'h2: tickOf = &d[1:0];
            default: tickOf = &d;
        endcase
    endfunction : tickOf

    always_ff @(posedge mclk) begin
        if (srst) begin
            divCnt <= DIV_RESET;
        end else begin
            divCnt <= divCnt + 3'h1;
        end
    end

    // divided system clock, one-cycle enables
    assign byteTick = tickOf(byteCtl[BC_CLK_HI:BC_CLK_LO], divCnt); // [RULE_24]
    assign wordTick = tickOf(wordCtl[WC_CLK_HI:WC_CLK_LO], divCnt); // [RULE_24]

    // ------------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------------
    logic inSel, rise, fall, edgeEvt;
    assign inSel = commonCtl[CC_SELECT] ? demodInputB : demodInputA; // [RULE_02]
    assign rise = inSel && !prevIn;
    assign fall = !inSel && prevIn;

    always_comb begin
        case (logicSel) // [RULE_04]
            EDGE_FALL: edgeEvt = demod && fall;
            EDGE_RISE: edgeEvt = demod && rise;
            EDGE_BOTH: edgeEvt = demod && (rise || fall);
            default: edgeEvt = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            prevIn <= 1'b0;
        end else begin
            prevIn <= inSel;
        end
    end

    // ------------------------------------------------------------------
    // terminal counts and capture events
    // ------------------------------------------------------------------
    logic byteTc, wordTc, byteCapEvt, wordEdgeCap, wordTcCap, wordCapEvt;
    assign byteTc = byteRun && byteTick && (byteCount == 8'h00); // [RULE_23]
    assign wordTc = wordRun && wordTick && (wordCount == 16'h0000); // [RULE_23]
    assign byteCapEvt = byteRun && edgeEvt;
    // every edge, or only the first one after arming
    assign wordEdgeCap = wordRun && edgeEvt
                         && (!wSingle || !firstDone); // [RULE_08] [RULE_09]
    assign wordTcCap = wordRun && demod && wSingle && firstDone
                       && byteTc; // [RULE_10]
    assign wordCapEvt = wordEdgeCap || wordTcCap;

    // ------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------
    always_comb begin
        next_byteRun = byteRun;
        next_wordRun = wordRun;
        if (ppOn && byteTc) begin
            next_byteRun = 1'b0; // [RULE_19]
            next_wordRun = 1'b1;
        end else if (ppOn && wordTc) begin
            next_wordRun = 1'b0; // [RULE_20]
            next_byteRun = 1'b1;
        end else begin
            if (byteTc && bSingle && !demod) begin
                next_byteRun = 1'b0;
            end
            if (wordTc && wSingle && !demod) begin
                next_wordRun = 1'b0;
            end
        end
        // software start or stop has the last word
        if (wrAt(IDX_BYTE_TIMER_CONTROL)) begin
            next_byteRun = pwdata[TC_ENABLE];
        end
        if (wrAt(IDX_WORD_TIMER_CONTROL)) begin
            next_wordRun = pwdata[TC_ENABLE];
        end
        if (wrAt(IDX_TIMER_ENABLE_LOCKSTEP)) begin // [RULE_17]
            if (syncEn) begin
                next_byteRun = pwdata[EL_BYTE_EN] || pwdata[EL_WORD_EN];
                next_wordRun = pwdata[EL_BYTE_EN] || pwdata[EL_WORD_EN];
            end else begin
                next_byteRun = pwdata[EL_BYTE_EN];
                next_wordRun = pwdata[EL_WORD_EN];
            end
        end
    end

    assign byteStart = next_byteRun && !byteRun;
    assign wordStart = next_wordRun && !wordRun;

    always_ff @(posedge mclk) begin
        if (srst) begin
            byteRun <= 1'b0;
            wordRun <= 1'b0;
        end else begin
            byteRun <= next_byteRun;
            wordRun <= next_wordRun;
        end
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            byteCtl <= REG_RESET;
            wordCtl <= REG_RESET;
            commonCtl <= REG_RESET; // [RULE_01] [RULE_03]
            syncEn <= 1'b0; // [RULE_17]
            byteReloadLow <= REG_RESET;
            byteReloadHigh <= REG_RESET;
            wordReloadLow <= REG_RESET;
            wordReloadHigh <= REG_RESET;
        end else if (wr) begin
            case (idx)
                IDX_BYTE_TIMER_CONTROL: byteCtl <= pwdata[7:0];
                IDX_TIMER_COMMON_CONTROL: commonCtl <= pwdata[7:0];
                IDX_WORD_TIMER_CONTROL: wordCtl <= pwdata[7:0];
                IDX_TIMER_ENABLE_LOCKSTEP: syncEn <= pwdata[EL_SYNC];
                IDX_BYTE_RELOAD_LOW: byteReloadLow <= pwdata[7:0];
                IDX_BYTE_RELOAD_HIGH: byteReloadHigh <= pwdata[7:0];
                IDX_WORD_RELOAD_LOW: wordReloadLow <= pwdata[7:0];
                IDX_WORD_RELOAD_HIGH: wordReloadHigh <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // sticky timeout, a hardware set wins over the clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            wordTimeout <= 1'b0;
        end else if (wordTc) begin
            wordTimeout <= 1'b1; // [RULE_12] [RULE_13]
        end else if (wrAt(IDX_WORD_TIMER_CONTROL) && pwdata[WC_TIMEOUT]) begin
            wordTimeout <= 1'b0; // [RULE_13]
        end
    end

    // first-edge latch, rearmed by writing the edge bit to 0
    always_ff @(posedge mclk) begin
        if (srst) begin
            firstDone <= 1'b0;
        end else if (!wSingle) begin
            firstDone <= 1'b0; // [RULE_11]
        end else if (wordEdgeCap) begin
            firstDone <= 1'b1; // [RULE_09]
        end
    end

    // ------------------------------------------------------------------
    // byte timer
    // ------------------------------------------------------------------
    logic byteStartLevel;
    assign byteStartLevel = ppOn ? commonCtl[CC_BYTE_INIT] : byteLevel;

    always_ff @(posedge mclk) begin
        if (srst) begin
            byteCount <= REG_RESET;
            byteLevel <= 1'b0;
        end else if (byteStart) begin
            byteLevel <= byteStartLevel; // [RULE_19]
            byteCount <= byteStartLevel ? byteReloadHigh : byteReloadLow;
        end else if (byteCapEvt) begin
            byteCount <= byteReloadHigh;
        end else if (byteTc && !demod) begin
            byteLevel <= !byteLevel;
            byteCount <= byteLevel ? byteReloadLow : byteReloadHigh;
        end else if (byteRun && byteTick) begin
            byteCount <= byteCount - 8'h01; // [RULE_23]
        end
    end

    // rising edge ends a low phase, falling edge ends a high phase
    always_ff @(posedge mclk) begin
        if (srst) begin
            byteCaptureLow <= REG_RESET;
            byteCaptureHigh <= REG_RESET;
        end else if (byteCapEvt) begin
            if (rise) begin
                byteCaptureLow <= byteCount;
            end else begin
                byteCaptureHigh <= byteCount;
            end
        end
    end

    // ------------------------------------------------------------------
    // word timer
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            wordCount <= {REG_RESET, REG_RESET};
            wordLevel <= 1'b0;
        end else if (wordStart) begin
            if (ppOn) begin
                wordLevel <= commonCtl[CC_WORD_INIT]; // [RULE_20]
            end
            wordCount <= {wordReloadHigh, wordReloadLow};
        end else if (wordEdgeCap) begin
            wordCount <= {wordReloadHigh, wordReloadLow}; // [RULE_08]
        end else if (wordTc && !demod) begin
            wordLevel <= !wordLevel;
            wordCount <= {wordReloadHigh, wordReloadLow};
        end else if (wordRun && wordTick) begin
            // zero rolls over to FFFF while demodulating
            wordCount <= wordCount - 16'h0001; // [RULE_12] [RULE_23]
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wordCaptureLow <= REG_RESET;
            wordCaptureHigh <= REG_RESET;
        end else if (wordCapEvt) begin
            wordCaptureLow <= wordCount[7:0]; // [RULE_10]
            wordCaptureHigh <= wordCount[15:8];
        end
    end

    // ------------------------------------------------------------------
    // interrupt request pulses
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            byteIrq <= 1'b0;
            wordIrq <= 1'b0;
        end else begin
            byteIrq <= (byteCapEvt && byteCtl[BC_CAP_IE])
                       || (byteTc && byteCtl[TC_CNT_IE]); // [RULE_05] [RULE_06]
            wordIrq <= (wordCapEvt && wordCtl[WC_CAP_IE])
                       || (wordTc && wordCtl[TC_CNT_IE]); // [RULE_14] [RULE_15]
        end
    end

    // ------------------------------------------------------------------
    // output pins
    // ------------------------------------------------------------------
    logic combLevel;
    always_comb begin
        case (logicSel) // [RULE_03]
            LOGIC_AND: combLevel = byteLevel & wordLevel;
            LOGIC_OR: combLevel = byteLevel | wordLevel;
            LOGIC_NOR: combLevel = !(byteLevel | wordLevel);
            LOGIC_NAND: combLevel = !(byteLevel & wordLevel);
            default: combLevel = 1'b0;
        endcase
    end

    // registered so the pins never glitch on a field change
    always_ff @(posedge mclk) begin
        if (srst) begin
            byteTimerOutPin <= 1'b0;
            wordTimerOutPin <= 1'b0;
            combinedOutPin <= 1'b0;
        end else begin
            byteTimerOutPin <= byteCtl[TC_PIN_SEL] ? byteLevel
                                                   : portOutByte; // [RULE_07]
            wordTimerOutPin <= wordCtl[TC_PIN_SEL] ? wordLevel
                                                   : portOutWord; // [RULE_16]
            combinedOutPin <= (!demod && commonCtl[CC_SELECT]) ? combLevel
                                             : portOutCombined; // [RULE_02]
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    always_comb begin
        case (idx)
            IDX_BYTE_TIMER_CONTROL: rd8 = {byteRun, byteCtl[6:0]};
            IDX_TIMER_COMMON_CONTROL: rd8 = commonCtl;
            IDX_WORD_TIMER_CONTROL:
                rd8 = {wordRun, wordCtl[6], wordTimeout, wordCtl[4:0]};
            IDX_TIMER_ENABLE_LOCKSTEP:
                rd8 = {wordRun, byteRun, syncEn, 5'h00}; // [RULE_17]
            IDX_BYTE_RELOAD_LOW: rd8 = byteReloadLow;
            IDX_BYTE_RELOAD_HIGH: rd8 = byteReloadHigh;
            IDX_WORD_RELOAD_LOW: rd8 = wordReloadLow;
            IDX_WORD_RELOAD_HIGH: rd8 = wordReloadHigh;
            IDX_WORD_CAPTURE_LOW: rd8 = wordCaptureLow;
            IDX_WORD_CAPTURE_HIGH: rd8 = wordCaptureHigh;
            IDX_BYTE_CAPTURE_LOW: rd8 = byteCaptureLow;
            IDX_BYTE_CAPTURE_HIGH: rd8 = byteCaptureHigh;
            default: rd8 = 8'h00;
        endcase
    end

    // sampled in the setup cycle, stable through the access cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            prdata <= {24'h000000, addrOk ? rd8 : 8'h00};
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence seqPpByteEnd;
        ppOn && byteTc && !wr;
    endsequence

    sequence seqFirstEdgeIgnored;
        wordRun && demod && wSingle && firstDone && edgeEvt && !byteTc;
    endsequence

    chk_timeout_sets: assert property ( // [RULE_12]
        wordTc |=> wordTimeout)
        else $error("word timeout status not set at terminal count");

    chk_timeout_sticky: assert property ( // [RULE_13]
        wordTimeout && !(wrAt(IDX_WORD_TIMER_CONTROL) && pwdata[WC_TIMEOUT])
        |=> wordTimeout)
        else $error("word timeout status dropped without a clear");

    chk_wrap_ffff: assert property ( // [RULE_12]
        wordTc && demod && !wordEdgeCap && !wordStart
        |=> wordCount == 16'hFFFF)
        else $error("word timer did not wrap to FFFF");

    chk_word_tout_irq: assert property ( // [RULE_15]
        wordTc && wordCtl[TC_CNT_IE] |=> wordIrq)
        else $error("word timeout interrupt missing");

    chk_byte_tout_irq: assert property ( // [RULE_06]
        byteTc && byteCtl[TC_CNT_IE] |=> byteIrq)
        else $error("byte timeout interrupt missing");

    chk_byte_cap_irq: assert property ( // [RULE_05]
        byteCapEvt && byteCtl[BC_CAP_IE] |=> byteIrq)
        else $error("byte capture interrupt missing");

    chk_first_edge_only: assert property ( // [RULE_09]
        seqFirstEdgeIgnored |=> $stable(wordCaptureLow)
        && $stable(wordCaptureHigh))
        else $error("word timer captured a later edge");

    chk_pp_handover: assert property ( // [RULE_19]
        seqPpByteEnd |=> wordRun && !byteRun
        && wordLevel == $past(commonCtl[CC_WORD_INIT]))
        else $error("ping-pong handover to word timer failed");

    chk_comb_logic: assert property ( // [RULE_03]
        !demod && commonCtl[CC_SELECT] && logicSel == LOGIC_NOR
        |=> combinedOutPin == !($past(byteLevel) | $past(wordLevel)))
        else $error("combined pin does not follow NOR");

    chk_byte_pin_sel: assert property ( // [RULE_07]
        byteCtl[TC_PIN_SEL] |=> byteTimerOutPin == $past(byteLevel))
        else $error("byte pin does not show timer level");

endmodule : dtcd_timer

// ---- bench/dtcd_carrier_src.sv ----
// Purpose: carrier source on the demod inputs
// Assumes: lines are sampled on mclk
// Notes: mark 4 cycles, space 4, inside the timer input limits
`timescale 1ns/100ps
module dtcd_carrier_src (
    input wire logic mclk,
    output logic demodInputA,
    output logic demodInputB
);
    initial begin
        demodInputA = 1'b0;
        demodInputB = 1'b0;
    end
    task automatic burst(input logic onB);
        @(posedge mclk);
        demodInputA <= ~onB;
        demodInputB <= onB;
        repeat (4) @(posedge mclk);
        demodInputA <= 1'b0;
        demodInputB <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : burst
endmodule : dtcd_carrier_src

// ---- bench/dtcd_timer_tb_top.sv ----
// Purpose: register-level test of the dual timer
// Assumes: zero-wait apb slave, irq outputs are pulses
// Notes: irq pulses are counted, deltas compared
`timescale 1ns/100ps
module dtcd_timer_tb_top import dtcd_pkg::*;;
    logic mclk, srst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic portOutByte, portOutWord, portOutCombined, byteIrq, wordIrq;
    logic byteTimerOutPin, wordTimerOutPin, combinedOutPin;
    logic demodInputA, demodInputB;
    logic [7:0] q, e;
    logic [7:0] edgeCnt [4] = '{8'h01, 8'h01, 8'h02, 8'h00};
    int nMismatch, totalChecks, cyc, nB, nW, n0, n1;
    dtcd_timer dtcd_timer_inst (.mclk(mclk), .srst(srst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .demodInputA(demodInputA), .demodInputB(demodInputB),
        .portOutByte(portOutByte), .portOutWord(portOutWord),
        .portOutCombined(portOutCombined), .byteIrq(byteIrq),
        .byteTimerOutPin(byteTimerOutPin), .wordIrq(wordIrq),
        .wordTimerOutPin(wordTimerOutPin), .combinedOutPin(combinedOutPin));
    dtcd_carrier_src dtcd_carrier_src_inst (.mclk(mclk),
        .demodInputA(demodInputA), .demodInputB(demodInputB));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // -------------------------------------------------
    // irq pulse counters and hang guard
    // -------------------------------------------------
    always @(posedge mclk) begin
        cyc++;
        if (byteIrq === 1'b1) nB++;
        if (wordIrq === 1'b1) nW++;
        if (cyc == 20000) begin
            nMismatch++;
            tallyAndFinish();
        end
    end
    task xfer(input logic w, input logic [3:0] i, input logic [7:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, i, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata[7:0];
        e = {7'h0, pslverr};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task chk(input logic [7:0] g, input logic [7:0] x);
        totalChecks++;
        if (g !== x) begin
            nMismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk
    task pulses(input logic b, input int k);
        repeat (k) dtcd_carrier_src_inst.burst(b);
        repeat (4) @(posedge mclk);
    endtask : pulses
    task tallyAndFinish;
        $display("checks=%0d mismatches=%0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tallyAndFinish
    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} = '0;
        srst = 1'b1;
        {portOutByte, portOutWord, portOutCombined} = 3'h0;
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        xfer(0, IDX_TIMER_COMMON_CONTROL, 0);
        chk(q, REG_RESET);
        xfer(0, IDX_TIMER_ENABLE_LOCKSTEP, 0);
        chk(q, REG_RESET);
        xfer(0, 4'hC, 0);
        chk(e, 8'h01);
        {portOutByte, portOutWord, portOutCombined} <= 3'h7;
        repeat (3) @(posedge mclk);
        chk({6'h0, byteTimerOutPin, wordTimerOutPin}, 8'h03);
        xfer(1, IDX_BYTE_TIMER_CONTROL, 8'h01);
        xfer(1, IDX_WORD_TIMER_CONTROL, 8'h01);
        for (int i = 0; i < 4; i++) begin
            xfer(1, IDX_TIMER_COMMON_CONTROL, 8'h40 | 8'(i << 4));
            repeat (3) @(posedge mclk);
            chk({byteTimerOutPin, wordTimerOutPin, combinedOutPin}, {7'h0, i[1]});
        end
        xfer(1, IDX_TIMER_COMMON_CONTROL, 8'h00);
        repeat (3) @(posedge mclk);
        chk({7'h0, combinedOutPin}, 8'h01);
        xfer(1, IDX_WORD_RELOAD_LOW, 8'h03);
        n1 = nW;
        xfer(1, IDX_WORD_TIMER_CONTROL, 8'h82);
        repeat (20) @(posedge mclk);
        xfer(0, IDX_TIMER_ENABLE_LOCKSTEP, 0);
        chk(q, 8'h80);
        xfer(0, IDX_WORD_TIMER_CONTROL, 0);
        chk(q & 8'hA0, 8'hA0);
        chk(8'(nW > n1), 8'h01);
        xfer(1, IDX_WORD_TIMER_CONTROL, 8'h00);
        xfer(1, IDX_WORD_TIMER_CONTROL, 8'h20);
        xfer(0, IDX_WORD_TIMER_CONTROL, 0);
        chk(q, 8'h00);
        xfer(1, IDX_BYTE_RELOAD_HIGH, 8'hF0);
        xfer(1, IDX_BYTE_TIMER_CONTROL, 8'h88);
        for (int c = 0; c < 4; c++) begin
            xfer(1, IDX_TIMER_COMMON_CONTROL, 8'h80 | 8'(c << 4));
            n0 = nB;
            pulses(1'b0, 1);
            chk(8'(nB - n0), edgeCnt[c]);
        end
        xfer(1, IDX_TIMER_COMMON_CONTROL, 8'hD0);
        n0 = nB;
        pulses(1'b0, 1);
        pulses(1'b1, 1);
        chk(8'(nB - n0), 8'h01);
        xfer(1, IDX_BYTE_TIMER_CONTROL, 8'h00);
        xfer(1, IDX_WORD_TIMER_CONTROL, 8'h84);
        n1 = nW;
        pulses(1'b1, 2);
        chk(8'(nW - n1), 8'h02);
        xfer(1, IDX_WORD_TIMER_CONTROL, 8'hC4);
        n1 = nW;
        pulses(1'b1, 2);
        chk(8'(nW - n1), 8'h01);
        xfer(1, IDX_WORD_TIMER_CONTROL, 8'h84);
        xfer(1, IDX_WORD_TIMER_CONTROL, 8'hC4);
        n1 = nW;
        pulses(1'b1, 2);
        chk(8'(nW - n1), 8'h01);
        n0 = nB;
        n1 = nW;
        xfer(1, IDX_BYTE_TIMER_CONTROL, 8'h82);
        repeat (300) @(posedge mclk);
        xfer(1, IDX_BYTE_TIMER_CONTROL, 8'h00);
        chk(8'(nB - n0), 8'h01);
        chk(8'(nW - n1), 8'h01);
        xfer(1, IDX_WORD_TIMER_CONTROL, 8'h62);
        xfer(1, IDX_BYTE_TIMER_CONTROL, 8'h42);
        xfer(1, IDX_TIMER_COMMON_CONTROL, 8'h05);
        n0 = nB;
        n1 = nW;
        xfer(1, IDX_BYTE_TIMER_CONTROL, 8'hC2);
        repeat (50) @(posedge mclk);
        xfer(0, IDX_TIMER_ENABLE_LOCKSTEP, 0);
        chk(8'($countones(q[7:6])), 8'h01);
        chk(8'(nB - n0 > 4 && nW - n1 > 4), 8'h01);
        xfer(1, IDX_TIMER_COMMON_CONTROL, 8'h00);
        repeat (20) @(posedge mclk);
        xfer(0, IDX_TIMER_ENABLE_LOCKSTEP, 0);
        chk(q, 8'h00);
        tallyAndFinish();
    end
endmodule : dtcd_timer_tb_top
